// *** irq_source.sv ***
// interrupt source model that raises a wake-up request after a chosen delay
`timescale 1ns/1ps
module irq_source (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // bench control
    input  wire logic       fire,
    input  wire logic [2:0] irqDelay,
    // core side
    input  wire logic       resume,
    output logic            irqRequest
);
    logic [3:0] count_q;
    logic       armed_q;
    // request held as a level until the core resumes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_q    <= 1'b0;
            count_q    <= 4'h0;
            irqRequest <= 1'b0;
        end else if (fire) begin
            armed_q <= 1'b1;
            count_q <= {1'b0, irqDelay};
        end else if (armed_q && count_q == 4'h0) begin
            armed_q    <= 1'b0;
            irqRequest <= 1'b1;
        end else if (armed_q) begin
            count_q <= count_q - 4'h1;
        end else if (resume) begin
            irqRequest <= 1'b0;
        end
    end
endmodule : irq_source

// *** power_down_consts.svh ***
// constants for the power-down mode controller
// Overview of operation
// - The sleep instruction enters light sleep when the depth select is clear, deep sleep when set.
// - In light sleep the core stops while oscillator, interrupts, timers and sound generator run.
// - Entering any power-down state keeps registers, memory and pin levels unchanged.
// - In deep sleep the core stops and timers and sound generator run only on the slow oscillator.
// - The halt instruction enters stop mode, with timers and sound running only on slow clock.
// - Light and deep sleep are left on any interrupt request or on reset.
// - Stop mode ignores interrupts and is left only through hardware reset.
// - An interrupt wakes a sleeping core even when masked, and then no service routine is taken.
// - With the mask clear, waking by interrupt fetches the vector and runs its service routine.
// - Waking from deep sleep inserts oscillator warm-up cycles before execution resumes.
// - Leaving stop mode through reset also applies the oscillator warm-up cycles.
`ifndef POWER_DOWN_CONSTS_SVH
`define POWER_DOWN_CONSTS_SVH
`define PD_WARMUP_CYCLES 16'h0400
`define PD_WARMUP_ZERO   16'h0000
`define PD_WARMUP_ONE    16'h0001
`define PD_WARMUP_MIN    16'h0008
`endif

// *** power_down_mode_control.sv ***
// power-down mode controller: sleep, deep sleep, stop and wake-up
`timescale 1ns/1ps
`include "power_down_consts.svh"
module power_down_mode_control #(
    parameter logic [15:0] WARMUP_CYCLES = `PD_WARMUP_CYCLES
) (
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           reset_n,
    // core requests
    input  wire logic                           sleepInstr,
    input  wire logic                           haltInstr,
    input  wire logic                           deepSelect,
    input  wire logic                           irqMask,
    // interrupt sources
    input  wire logic                           irqRequest,
    // peripheral clock sources
    input  wire logic                           timerOnSlow,
    input  wire logic                           soundOnSlow,
    // controls
    output power_down_pkg::clock_gate_type      gates,
    output power_down_pkg::wake_type            wake,
    output power_down_pkg::pd_state_type        state
);
    power_down_pkg::pd_state_type state_d;
    logic                         warmStart;
    logic                         warmDone;
    logic                         resetWarm_q;
    logic                         warmTakeVec_q;
    logic [15:0]                  warmAge_q;

    // the fixed assertion windows below need at least this many warm-up cycles
    if (WARMUP_CYCLES < `PD_WARMUP_MIN) begin : warmup_too_short
        $error("warm-up count below minimum");
    end

    warmup_counter #(.CYCLES(WARMUP_CYCLES)) warmup (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .start    (warmStart),
        .done     (warmDone)
    );

    // hardware reset always warms the oscillator, covering exit from stop
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) resetWarm_q <= 1'b1;
        else          resetWarm_q <= 1'b0;
    end

    assign warmStart = resetWarm_q || (state == power_down_pkg::DEEP_SLEEP && irqRequest);

    always_comb begin
        state_d = state;
        unique case (state)
            power_down_pkg::RUN: begin
                if (haltInstr) state_d = power_down_pkg::STOP;
                else if (sleepInstr) begin
                    state_d = deepSelect ? power_down_pkg::DEEP_SLEEP
                                         : power_down_pkg::LIGHT_SLEEP;
                end
            end
            power_down_pkg::LIGHT_SLEEP: begin
                if (irqRequest) state_d = power_down_pkg::RUN;
            end
            power_down_pkg::DEEP_SLEEP: begin
                if (irqRequest) state_d = power_down_pkg::WARMUP;
            end
            power_down_pkg::STOP: begin
                state_d = power_down_pkg::STOP;
            end
            power_down_pkg::WARMUP: begin
                if (warmDone) state_d = power_down_pkg::RUN;
            end
            default: state_d = power_down_pkg::RUN;
        endcase
    end

    // reset lands in warm-up so the core waits for the oscillator
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) state <= power_down_pkg::WARMUP;
        else          state <= state_d;
    end

    // remembers whether the deep-sleep wake should take the vector
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) warmTakeVec_q <= 1'b0;
        else if (state == power_down_pkg::DEEP_SLEEP && irqRequest)
            warmTakeVec_q <= !irqMask;
    end

    // one-cycle resume pulse; vector only when mask is clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake <= '0;
        end else begin
            wake.resume     <= (state == power_down_pkg::LIGHT_SLEEP && irqRequest)
                            || (state == power_down_pkg::WARMUP && warmDone);
            wake.takeVector <= (state == power_down_pkg::LIGHT_SLEEP && irqRequest && !irqMask)
                            || (state == power_down_pkg::WARMUP && warmDone
                                && warmTakeVec_q);
        end
    end

    // clock gating per state; nothing here touches retained state
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gates <= '0;
        end else begin
            gates.coreRun        <= (state_d == power_down_pkg::RUN);
            gates.fastOscOn      <= (state_d == power_down_pkg::RUN)
                                 || (state_d == power_down_pkg::LIGHT_SLEEP)
                                 || (state_d == power_down_pkg::WARMUP);
            gates.timerFastEn    <= (state_d == power_down_pkg::RUN)
                                 || (state_d == power_down_pkg::LIGHT_SLEEP)
                                 || timerOnSlow;
            gates.soundFastEn    <= (state_d == power_down_pkg::RUN)
                                 || (state_d == power_down_pkg::LIGHT_SLEEP)
                                 || soundOnSlow;
            gates.slowOnlyPeriph <= (state_d == power_down_pkg::DEEP_SLEEP)
                                 || (state_d == power_down_pkg::STOP);
        end
    end

    // cycles spent in warm-up, watched by the warm-up length check
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) warmAge_q <= `PD_WARMUP_ZERO;
        else if (state != power_down_pkg::WARMUP) warmAge_q <= `PD_WARMUP_ZERO;
        else if (warmAge_q != '1) warmAge_q <= warmAge_q + `PD_WARMUP_ONE;
    end

    light_enter_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::RUN && sleepInstr && !haltInstr && !deepSelect
        |=> state == power_down_pkg::LIGHT_SLEEP)
        else $error("light sleep not entered");

    deep_enter_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::RUN && sleepInstr && !haltInstr && deepSelect
        |=> state == power_down_pkg::DEEP_SLEEP)
        else $error("deep sleep not entered");

    halt_enter_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::RUN && haltInstr
        |=> state == power_down_pkg::STOP ##1 !gates.coreRun)
        else $error("stop not entered");

    stop_holds_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::STOP
        |=> state == power_down_pkg::STOP)
        else $error("stop left without reset");

    light_wake_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::LIGHT_SLEEP && irqRequest
        |=> wake.resume && wake.takeVector == !$past(irqMask))
        else $error("light wake wrong");

    deep_warm_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::DEEP_SLEEP && irqRequest
        |=> !wake.resume [*8])
        else $error("deep wake skipped warm-up");

    masked_novec_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::LIGHT_SLEEP && irqRequest && irqMask
        |=> !wake.takeVector)
        else $error("masked wake took vector");

    sleep_core_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::LIGHT_SLEEP && $past(state) == power_down_pkg::LIGHT_SLEEP
        |-> !gates.coreRun && gates.fastOscOn)
        else $error("light sleep gating wrong");

    reset_warm_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        resetWarm_q
        |=> !gates.coreRun [*8])
        else $error("core ran before warm-up");

    deep_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::DEEP_SLEEP && $past(state) == power_down_pkg::DEEP_SLEEP
        |-> gates.timerFastEn == $past(timerOnSlow))
        else $error("deep timer gating wrong");

    deep_osc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::DEEP_SLEEP && $past(state) == power_down_pkg::DEEP_SLEEP
        |-> !gates.coreRun && !gates.fastOscOn && gates.soundFastEn == $past(soundOnSlow))
        else $error("deep sleep gating wrong");

    light_periph_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::LIGHT_SLEEP && $past(state) == power_down_pkg::LIGHT_SLEEP
        |-> gates.timerFastEn && gates.soundFastEn && !gates.slowOnlyPeriph)
        else $error("light sleep peripherals stopped");

    stop_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::STOP && $past(state) == power_down_pkg::STOP
        |-> !gates.coreRun && !gates.fastOscOn && gates.timerFastEn == $past(timerOnSlow)
        && gates.soundFastEn == $past(soundOnSlow))
        else $error("stop gating wrong");

    deep_wake_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::DEEP_SLEEP && irqRequest
        |=> state == power_down_pkg::WARMUP && !gates.coreRun)
        else $error("deep sleep not left on interrupt");

    stop_noirq_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::STOP && irqRequest
        |=> !wake.resume && !gates.coreRun)
        else $error("stop woke on interrupt");

    vector_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::LIGHT_SLEEP && irqRequest && !irqMask
        |=> wake.takeVector)
        else $error("unmasked wake skipped vector");

    warm_exit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::WARMUP && warmDone
        |=> state == power_down_pkg::RUN && wake.resume && gates.coreRun)
        else $error("warm-up end did not resume");

    warm_length_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == power_down_pkg::WARMUP && warmDone
        |-> warmAge_q >= WARMUP_CYCLES)
        else $error("warm-up too short");

    retain_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state != power_down_pkg::RUN && state != power_down_pkg::WARMUP && $past(state) == state
        |-> !gates.coreRun && !wake.resume)
        else $error("core moved in power-down");

    resume_run_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wake.resume
        |-> state == power_down_pkg::RUN && gates.coreRun)
        else $error("resume without running core");

    resume_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wake.resume
        |=> !wake.resume)
        else $error("resume longer than one cycle");
endmodule : power_down_mode_control

// *** power_down_mode_control_bench.sv ***
// self-checking bench for the power-down mode controller
`timescale 1ns/1ps
module power_down_mode_control_bench;
    logic                           core_clk    = 1'b0;
    logic                           reset_n     = 1'b0;
    logic                           sleepInstr  = 1'b0;
    logic                           haltInstr   = 1'b0;
    logic                           deepSelect  = 1'b0;
    logic                           irqMask     = 1'b0;
    logic                           timerOnSlow = 1'b0;
    logic                           soundOnSlow = 1'b0;
    logic                           fire        = 1'b0;
    logic [2:0]                     irqDelay    = 3'h0;
    logic                           irqRequest;
    logic                           sawWarm;
    power_down_pkg::clock_gate_type gates;
    power_down_pkg::wake_type       wake;
    power_down_pkg::pd_state_type   state;
    int                             fail_count  = 0;
    int                             checks      = 0;
    always #50 core_clk = ~core_clk;
    power_down_mode_control #(.WARMUP_CYCLES(16'h0008)) dut (.core_clk, .reset_n, .sleepInstr,
        .haltInstr, .deepSelect, .irqMask, .irqRequest, .timerOnSlow, .soundOnSlow, .gates,
        .wake, .state);
    irq_source partner (.core_clk, .reset_n, .fire, .irqDelay, .resume(wake.resume),
        .irqRequest);
    function automatic power_down_pkg::pd_state_type exp_state(input logic deep);
        return deep ? power_down_pkg::DEEP_SLEEP : power_down_pkg::LIGHT_SLEEP;
    endfunction : exp_state
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic pulse(input logic halt);
        @(posedge core_clk);
        if (halt) haltInstr <= 1'b1;
        else sleepInstr <= 1'b1;
        @(posedge core_clk);
        haltInstr  <= 1'b0;
        sleepInstr <= 1'b0;
        #1;
    endtask : pulse
    task automatic wait_run();
        sawWarm = 1'b0;
        for (int n = 0; n < 40; n++) begin
            @(posedge core_clk);
            #1;
            if (state === power_down_pkg::WARMUP) sawWarm = 1'b1;
            if (state === power_down_pkg::RUN) return;
        end
        check(1'b0, "no return to run");
        give_verdict();
    endtask : wait_run
    initial begin
        void'($urandom(77));
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        wait_run();
        check(sawWarm === 1'b1 && wake.resume === 1'b1, "warm-up after reset");
        check(gates.coreRun === 1'b1, "core idle after reset");
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk);
            deepSelect  <= 1'($urandom % 2);
            irqMask     <= 1'($urandom % 2);
            timerOnSlow <= 1'($urandom % 2);
            soundOnSlow <= 1'($urandom % 2);
            irqDelay    <= 3'($urandom % 8);
            pulse(1'b0);
            check(state === exp_state(deepSelect), "sleep depth");
            check(gates.coreRun === 1'b0, "core not stopped");
            check(gates.fastOscOn === ~deepSelect, "fast oscillator");
            check(gates.timerFastEn === (!deepSelect || timerOnSlow), "timer gating");
            check(gates.soundFastEn === (!deepSelect || soundOnSlow), "sound gating");
            check(gates.slowOnlyPeriph === deepSelect, "slow-only peripherals");
            @(posedge core_clk) fire <= 1'b1;
            @(posedge core_clk) fire <= 1'b0;
            wait_run();
            check(sawWarm === deepSelect, "warm-up on wake");
            check(wake.resume === 1'b1, "no resume");
            check(wake.takeVector === ~irqMask, "vector fetch");
            check(gates.coreRun === 1'b1 && gates.fastOscOn === 1'b1, "core not running");
            $display("sleep test %0d done", i);
        end
        pulse(1'b1);
        check(state === power_down_pkg::STOP, "stop entry");
        check(gates.coreRun === 1'b0 && gates.fastOscOn === 1'b0, "stop core clock");
        check(gates.timerFastEn === timerOnSlow, "stop timer gating");
        check(gates.soundFastEn === soundOnSlow, "stop sound gating");
        check(gates.slowOnlyPeriph === 1'b1, "stop slow-only peripherals");
        @(posedge core_clk) fire <= 1'b1;
        @(posedge core_clk) fire <= 1'b0;
        pulse(1'b0);
        repeat (10) @(posedge core_clk);
        #1;
        check(state === power_down_pkg::STOP, "stop left without reset");
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        wait_run();
        check(sawWarm === 1'b1, "warm-up after stop");
        check(gates.coreRun === 1'b1 && wake.resume === 1'b1, "no run after stop");
        $display("stop test done");
        give_verdict();
    end
endmodule : power_down_mode_control_bench

// *** power_down_pkg.sv ***
// types shared by the power-down mode controller
package power_down_pkg;
    typedef enum logic [2:0] {
        RUN, LIGHT_SLEEP, DEEP_SLEEP, STOP, WARMUP
    } pd_state_type;
    typedef struct packed {
        logic coreRun;
        logic fastOscOn;
        logic timerFastEn;
        logic soundFastEn;
        logic slowOnlyPeriph;
    } clock_gate_type;
    typedef struct packed {
        logic resume;
        logic takeVector;
    } wake_type;
endpackage : power_down_pkg

// *** warmup_counter.sv ***
// oscillator warm-up counter
`timescale 1ns/1ps
`include "power_down_consts.svh"
module warmup_counter #(
    parameter logic [15:0] CYCLES = `PD_WARMUP_CYCLES
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // control
    input  wire logic start,
    output logic      done
);
    logic [15:0] count_q;
    if (CYCLES == `PD_WARMUP_ZERO) begin : zero_cycles
        $error("warm-up count must be nonzero");
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= `PD_WARMUP_ZERO;
            done    <= 1'b0;
        end else if (start) begin
            count_q <= CYCLES;
            done    <= 1'b0;
        end else if (count_q != `PD_WARMUP_ZERO) begin
            count_q <= count_q - `PD_WARMUP_ONE;
            done    <= (count_q == `PD_WARMUP_ONE);
        end else begin
            done <= 1'b0;
        end
    end
endmodule : warmup_counter
